// >>> core/spg_pkg.sv
package spg_pkg;
  localparam int SPG_LINES = 8;
  localparam int SPG_AW    = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] SPG_IDX_CONNECT   = 8'h12;
  localparam logic [7:0] SPG_IDX_DIRECTION = 8'h13;
  localparam logic [7:0] SPG_IDX_DATA      = 8'h14;
  localparam logic [7:0] SPG_RST_CONNECT   = 8'h00;
  localparam logic [7:0] SPG_RST_DIRECTION = 8'h00;
  localparam logic [7:0] SPG_RST_DATA      = 8'h00;
  localparam logic [1:0] SPG_BYTE_ALIGN    = 2'h0;
  localparam logic [31:0] SPG_UNMAPPED_RD  = 32'h0000_0000;
  localparam logic        SPG_DIR_OUT      = 1'b0;
  localparam logic        SPG_DIR_IN       = 1'b1;
  // Routing of line n to analog pin; pin 3..9 then common pin
  localparam int SPG_FIRST_ANALOG  = 3;
  localparam int SPG_COMMON_LINE   = 7;
endpackage

// >>> core/spg_cfg_if.sv
`timescale 1ns/100ps
interface spg_cfg_if
  import spg_pkg::*;
();
  logic [SPG_LINES-1:0] connect_bits;
  logic [SPG_LINES-1:0] direction;
  logic [SPG_LINES-1:0] level_bits;
  logic [SPG_LINES-1:0] pin_sync;
  modport regs (output connect_bits, output direction, output level_bits, input pin_sync);
  modport pins (input connect_bits, input direction, input level_bits, output pin_sync);
endinterface

// >>> core/spg_sync.sv
`timescale 1ns/100ps
module spg_sync
  import spg_pkg::*;
#(
  parameter int LINES = SPG_LINES
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [LINES-1:0] pin_i,
  spg_cfg_if.pins               cfg
);
  logic [LINES-1:0] meta_r;
  logic [LINES-1:0] sync_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= pin_i;  // R9
      sync_r <= meta_r; // R9
    end
  end

  assign cfg.pin_sync = sync_r;
endmodule // spg_sync

// >>> core/spg_top.sv
// Functional notes
// R1: Connect bits 0..6 route lines 0..6 to analog pins three to nine.
// R2: Connect bit 7 routes line 7 to the common analog pin.
// R3: A line attaches only while its connect bit is one; all zero after reset.
// R4: Direction bit zero makes a line output, one makes it input; reset output.
// R5: Pin-connection register, eight bits read/write at 12h, resets 00h.
// R6: Line-direction register, eight bits read/write at 13h, resets 00h.
// R7: Output lines read data zero; input lines' writes only store, never drive.
// R8: Data bits are line levels, zero low; data register at 14h, resets 00h.
// R9: Input pin levels pass a two-stage synchroniser before sampling.
`timescale 1ns/100ps
module spg_top
  import spg_pkg::*;
#(
  parameter int LINES = SPG_LINES
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [9:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [LINES-1:0] pin_i,
  output logic      [LINES-1:0] pin_o,
  output logic      [LINES-1:0] pin_oe_n_o,
  output logic      [LINES-1:0] attach_o
);
  spg_cfg_if cfg ();

  logic [LINES-1:0] connect_r;
  logic [LINES-1:0] direction_r;
  logic [LINES-1:0] data_r;
  logic [LINES-1:0] data_nxt;
  logic [31:0]      rd_nxt;
  logic             req;
  logic [7:0]       idx;
  logic             sel_conn;
  logic             sel_dir;
  logic             sel_data;
  logic             wr_lane0;

  spg_sync #(
    .LINES (LINES)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (pin_i),
    .cfg   (cfg.pins)
  );

  assign cfg.connect_bits = connect_r;
  assign cfg.direction    = direction_r;
  assign cfg.level_bits   = data_r;

  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx      = wb_adr_i[9:2];
  assign sel_conn = (idx == SPG_IDX_CONNECT)   && (wb_adr_i[1:0] == SPG_BYTE_ALIGN);
  assign sel_dir  = (idx == SPG_IDX_DIRECTION) && (wb_adr_i[1:0] == SPG_BYTE_ALIGN);
  assign sel_data = (idx == SPG_IDX_DATA)      && (wb_adr_i[1:0] == SPG_BYTE_ALIGN);
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      connect_r <= SPG_RST_CONNECT[LINES-1:0]; // R3 R5
    else if (wr_lane0 && sel_conn)
      connect_r <= wb_dat_i[LINES-1:0]; // R5
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      direction_r <= SPG_RST_DIRECTION[LINES-1:0]; // R4 R6
    else if (wr_lane0 && sel_dir)
      direction_r <= wb_dat_i[LINES-1:0]; // R6
  end

  // Inputs track the synchronised pin unless software writes this cycle
  always_comb
  begin
    data_nxt = data_r;
    for (int i = 0; i < LINES; i++)
    begin
      if (wr_lane0 && sel_data)
        data_nxt[i] = wb_dat_i[i]; // R7 R8
      else if (direction_r[i] == SPG_DIR_IN)
        data_nxt[i] = cfg.pin_sync[i]; // R8 R9
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_r <= SPG_RST_DATA[LINES-1:0]; // R8
    else
      data_r <= data_nxt;
  end

  always_comb
  begin
    rd_nxt = SPG_UNMAPPED_RD;
    if (sel_conn)
      rd_nxt[LINES-1:0] = connect_r;
    else if (sel_dir)
      rd_nxt[LINES-1:0] = direction_r;
    else if (sel_data)
      rd_nxt[LINES-1:0] = data_r & direction_r; // R7
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= SPG_UNMAPPED_RD;
    else if (req && !wb_we_i)
      wb_dat_o <= rd_nxt;
  end

  // Per line pad drive: attach, direction, level
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : g_line
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          attach_o[g]   <= 1'b0;
          pin_o[g]      <= 1'b0;
          pin_oe_n_o[g] <= 1'b1;
        end
        else
        begin
          attach_o[g]   <= connect_r[g]; // R1 R2 R3
          pin_o[g]      <= data_r[g];
          pin_oe_n_o[g] <= !(connect_r[g] && direction_r[g] == SPG_DIR_OUT); // R3 R4 R7
        end
      end
    end
  endgenerate

  property p_conn_reset;
    @(posedge clk_i) $fell(rst_i) |-> connect_r == SPG_RST_CONNECT[LINES-1:0];
  endproperty
  a_conn_reset: assert property (p_conn_reset) else $error("connect not reset"); // R5

  property p_dir_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_lane0 && sel_dir |=> direction_r == $past(wb_dat_i[LINES-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost"); // R6

  property p_conn_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_lane0 && sel_conn |=> connect_r == $past(wb_dat_i[LINES-1:0]);
  endproperty
  a_conn_write: assert property (p_conn_write) else $error("connect write lost"); // R5

  property p_attach;
    @(posedge clk_i) disable iff (rst_i)
      ##1 attach_o == $past(connect_r);
  endproperty
  a_attach: assert property (p_attach) else $error("attach mismatch"); // R3

  property p_attach_route;
    @(posedge clk_i) disable iff (rst_i)
      ##1 attach_o[SPG_COMMON_LINE] == $past(connect_r[SPG_COMMON_LINE]);
  endproperty
  a_attach_route: assert property (p_attach_route) else $error("common route wrong"); // R2

  property p_oe;
    @(posedge clk_i) disable iff (rst_i)
      ##1 pin_oe_n_o == ~($past(connect_r) & ~$past(direction_r));
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable wrong"); // R4

  property p_out_read_zero;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && sel_data |=> (wb_dat_o[LINES-1:0] & ~$past(direction_r)) == '0;
  endproperty
  a_out_read_zero: assert property (p_out_read_zero) else $error("output line read nonzero"); // R7

  property p_output_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && sel_data) |=>
        (data_r & ~$past(direction_r)) == ($past(data_r) & ~$past(direction_r));
  endproperty
  a_output_hold: assert property (p_output_hold) else $error("output data changed"); // R7

  property p_input_sample;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && sel_data) |=> ((data_r ^ $past(cfg.pin_sync)) & $past(direction_r)) == '0;
  endproperty
  a_input_sample: assert property (p_input_sample) else $error("input not sampled"); // R9

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles"); // R5 R6

  property p_dir_reset;
    @(posedge clk_i) $fell(rst_i) |-> direction_r == SPG_RST_DIRECTION[LINES-1:0];
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not reset"); // R4 R6

  property p_data_reset;
    @(posedge clk_i) $fell(rst_i) |-> data_r == SPG_RST_DATA[LINES-1:0];
  endproperty
  a_data_reset: assert property (p_data_reset) else $error("data not reset"); // R8

  property p_pads_reset;
    @(posedge clk_i) $fell(rst_i) |-> pin_oe_n_o == '1 && attach_o == '0;
  endproperty
  a_pads_reset: assert property (p_pads_reset) else $error("pads not released"); // R3

  property p_conn_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && sel_conn) |=> connect_r == $past(connect_r);
  endproperty
  a_conn_hold: assert property (p_conn_hold) else $error("connect changed"); // R5

  property p_dir_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && sel_dir) |=> direction_r == $past(direction_r);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed"); // R6

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked"); // R5 R6

  property p_ack_only_req;
    @(posedge clk_i) disable iff (rst_i)
      !req |=> !wb_ack_o;
  endproperty
  a_ack_only_req: assert property (p_ack_only_req) else $error("ack without request"); // R5 R6

  property p_read_conn;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && sel_conn |=> wb_dat_o[LINES-1:0] == $past(connect_r);
  endproperty
  a_read_conn: assert property (p_read_conn) else $error("connect read wrong"); // R5

  property p_read_dir;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && sel_dir |=> wb_dat_o[LINES-1:0] == $past(direction_r);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("direction read wrong"); // R6

  property p_read_upper;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i |=> (wb_dat_o >> LINES) == '0;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set"); // R5 R6

  property p_read_unmapped;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && !(sel_conn || sel_dir || sel_data) |=> wb_dat_o == SPG_UNMAPPED_RD;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read"); // R5 R6

  property p_data_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_lane0 && sel_data |=> data_r == $past(wb_dat_i[LINES-1:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost"); // R7 R8

  property p_lane_ignored;
    @(posedge clk_i) disable iff (rst_i)
      req && wb_we_i && !wb_sel_i[0] |=>
        connect_r == $past(connect_r) && direction_r == $past(direction_r);
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) else $error("masked write landed"); // R5 R6

  property p_pin_level;
    @(posedge clk_i) disable iff (rst_i)
      ##1 pin_o == $past(data_r);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong"); // R8

  property p_detached_float;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (pin_oe_n_o | $past(connect_r)) == '1;
  endproperty
  a_detached_float: assert property (p_detached_float) else $error("detached line driven"); // R3

  property p_input_float;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (pin_oe_n_o | ~$past(direction_r)) == '1;
  endproperty
  a_input_float: assert property (p_input_float) else $error("input line driven"); // R7
endmodule // spg_top

// >>> verif/spg_pad_model.sv
`timescale 1ns/100ps
module spg_pad_model
  import spg_pkg::*;
(
  input  wire logic [SPG_LINES-1:0] drv_i,
  input  wire logic [SPG_LINES-1:0] oe_n_i,
  input  wire logic [SPG_LINES-1:0] ext_i,
  output logic      [SPG_LINES-1:0] pad_o
);
  // Undriven lines follow the outside source
  assign pad_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule // spg_pad_model

// >>> verif/spg_top_tb.sv
`timescale 1ns/100ps
module spg_top_tb;
  import spg_pkg::*;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  pin_i, pin_o, pin_oe_n_o, attach_o;
  logic [7:0]  ext_lvl  = 8'h00;
  logic [3:0]  sel_v    = 4'hF;
  logic [7:0]  exp_q[$];
  logic [7:0]  c, d;
  int          miscompares = 0, total_checks = 0, cycles = 0, seed = 48570;

  always #2 clk_i = ~clk_i;

  spg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .attach_o(attach_o));
  spg_pad_model pad_u (.drv_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_i(ext_lvl), .pad_o(pin_i));

  task report_and_stop();
    if (exp_q.size() != 0)
      miscompares++;
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask

  // Classic single cycle; read expectations go to the queue
  task wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] ex);
    if (!we)
      exp_q.push_back(ex);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel_v;
    wb_dat_i <= {24'h0, wd};
    @(posedge clk_i iff wb_ack_o === 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      chk("rd_data", {24'h0, exp_q.pop_front()}, wb_dat_o);
    if (cycles == 3000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("oe_n", 8'hFF, pin_oe_n_o);
    chk("attach", 8'h00, attach_o);
    @(posedge clk_i);
    wb(1'b0, SPG_IDX_CONNECT, 8'h00, SPG_RST_CONNECT);
    wb(1'b0, SPG_IDX_DIRECTION, 8'h00, SPG_RST_DIRECTION);
    wb(1'b0, SPG_IDX_DATA, 8'h00, SPG_RST_DATA);
    c = 8'($random(seed));
    d = 8'($random(seed));
    wb(1'b1, SPG_IDX_CONNECT, c, 8'h00);
    wb(1'b1, SPG_IDX_DATA, d, 8'h00);
    wb(1'b1, 8'hFF, 8'h5A, 8'h00);
    wb(1'b0, 8'hFF, 8'h00, 8'h00);
    sel_v = 4'hE;
    wb(1'b1, SPG_IDX_CONNECT, ~c, 8'h00);
    sel_v = 4'hF;
    wb(1'b0, SPG_IDX_CONNECT, 8'h00, c);
    wb(1'b0, SPG_IDX_DATA, 8'h00, 8'h00);
    @(negedge clk_i);
    chk("attach", c, attach_o);
    chk("oe_n", {24'h0, ~c}, pin_oe_n_o);
    chk("pin_o", d & c, pin_o & c);
    @(posedge clk_i);
    ext_lvl <= 8'($random(seed));
    wb(1'b1, SPG_IDX_DIRECTION, 8'hFF, 8'h00);
    wb(1'b1, SPG_IDX_DATA, 8'h3C, 8'h00);
    repeat (4) @(posedge clk_i);
    wb(1'b0, SPG_IDX_DIRECTION, 8'h00, 8'hFF);
    wb(1'b0, SPG_IDX_DATA, 8'h00, ext_lvl);
    @(negedge clk_i);
    chk("oe_n", 8'hFF, pin_oe_n_o);
    report_and_stop();
  end
endmodule // spg_top_tb
